// [verilog/pcpw_pkg.sv]
/*
 Constants, field layouts and types of the counter array block:
 shared counter, six compare/PWM modules, module 5 watchdog.
 Assumes a single pclk domain and an APB register port.
 // Operation
 // RULE_01 - Timer mode: equal count sets flag, interrupt
 // RULE_02 - Flag stays set; only software write clears
 // RULE_03 - Timer mode: comparator and match bits set
 // RULE_04 - Low byte write clears, high sets comparator
 // RULE_05 - Software writes low byte before high byte
 // RULE_06 - High-speed mode toggles pin on each match
 // RULE_07 - Entering high-speed mode starts pin high
 // RULE_08 - Frequency mode: low match toggles, adds high
 // RULE_09 - Frequency mode select; high 0x00 means 256
 // RULE_10 - 8-bit PWM: match high, overflow low
 // RULE_11 - 8-bit PWM reloads low from high byte
 // RULE_12 - 8-bit PWM select; comparator off gives 0%
 // RULE_13 - 16-bit PWM: match high, overflow low
 // RULE_14 - 16-bit PWM select; comparator off gives 0%
 // RULE_15 - Software updates 16-bit duty at match interrupts
 // RULE_16 - Watchdog enable bit; enabled after reset
 // RULE_17 - Watchdog locks counter, timebase, module 5
 // RULE_18 - Run bit writes ignored; reads software value
 // RULE_19 - Module 5 high equal counter high resets
 // RULE_20 - High write reloads counter high plus offset
 // RULE_21 - Offset counts low byte overflows
 // RULE_22 - Reset at low overflow during high match
 // RULE_23 - Writing one to module 5 flag resets
 // RULE_24 - Lock enables watchdog until system reset
 // RULE_25 - Timebase select chooses six clock sources
 // RULE_26 - Events evaluated once per timebase tick
*/
package pcpw_pkg;
    localparam int        NMOD      = 6;
    localparam int        WD_MOD    = 5;
    localparam int        AW        = 8;
    localparam logic [7:0] OFS_CTRL  = 8'h00;
    localparam logic [7:0] OFS_MODE  = 8'h04;
    localparam logic [7:0] OFS_CNTL  = 8'h08;
    localparam logic [7:0] OFS_CNTH  = 8'h0c;
    localparam logic [7:0] OFS_MMODE = 8'h10;
    localparam logic [7:0] OFS_CMPL  = 8'h40;
    localparam logic [7:0] OFS_CMPH  = 8'h44;
    localparam int        CTRL_RUN  = 6;
    localparam int        MD_IDLE   = 7;
    localparam int        MD_WDEN   = 6;
    localparam int        MD_LOCK   = 5;
    localparam int        MD_TB_LSB = 1;
    localparam logic      WDEN_RST  = 1'b1;
    localparam logic [3:0] DIV12    = 4'hc;
    localparam logic [2:0] OSC_LAST = 3'h7;
    localparam logic [2:0] TB_DIV12 = 3'h0;
    localparam logic [2:0] TB_DIV4  = 3'h1;
    localparam logic [2:0] TB_T0OVF = 3'h2;
    localparam logic [2:0] TB_ECI   = 3'h3;
    localparam logic [2:0] TB_SYS   = 3'h4;
    localparam logic [2:0] TB_OSC8  = 3'h5;

    typedef struct packed {
        logic wide;
        logic ecom;
        logic capp;
        logic capn;
        logic mat;
        logic tog;
        logic pwm;
        logic irq_en;
    } pcpw_mode_t;

    typedef enum logic [5:0] {
        FN_OFF   = 6'h01,
        FN_TIMER = 6'h02,
        FN_HSO   = 6'h04,
        FN_FREQ  = 6'h08,
        FN_PWM8  = 6'h10,
        FN_PWM16 = 6'h20
    } pcpw_fn_t;

    function automatic pcpw_fn_t pcpw_decode(input pcpw_mode_t m);
        pcpw_fn_t f;
        f = FN_OFF;
        if (m.ecom && !m.capp && !m.capn) begin
            case ({m.mat, m.tog, m.pwm})
                3'b100:  f = FN_TIMER; // see RULE_03
                3'b110:  f = FN_HSO;   // see RULE_06
                3'b011:  f = FN_FREQ;  // see RULE_09
                3'b001:  f = m.wide ? FN_PWM16 : FN_PWM8; // see RULE_12 see RULE_14
                default: f = FN_OFF;
            endcase
        end
        return f;
    endfunction
endpackage

// [verilog/pcpw_counter_array.sv]
/*
 Counter array: shared 16-bit counter, six compare/PWM modules, module 5
 watchdog, APB register slave.
 Assumes pins and external clock arrive asynchronous; timer0 overflow is a
 one-cycle pulse on pclk.
*/
`timescale 1ns/1ps
module pcpw_counter_array (
    // Clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // APB
    input  wire logic [pcpw_pkg::AW-1:0]   paddr,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    // Timebase sources and CPU idle
    input  wire logic                      timer0_ovf,
    input  wire logic                      external_count_input,
    input  wire logic                      ext_osc_clk,
    input  wire logic                      cpu_idle,
    // Module outputs
    output logic [pcpw_pkg::NMOD-1:0]      module_io_pin,
    output logic                           irq_request,
    output logic                           watchdog_reset
);
    import pcpw_pkg::*;

    logic [2:0]      eci_q;
    logic [2:0]      osc_q;
    logic [3:0]      pre_q;
    logic [2:0]      osc_cnt_q;
    logic [15:0]     cnt_q;
    logic [15:0]     cnt_nxt;
    logic [7:0]      snap_q;
    logic            run_q;
    logic            wd_en_q;
    logic            lock_q;
    logic [2:0]      tb_q;
    logic            idle_q;
    logic            tb_src;
    logic            tick;
    logic            lo_ovf;
    logic            ovf16;
    logic            wr;
    logic            hit;
    logic            wd_hit;
    logic            wd_force;
    logic [31:0]     rd_d;
    logic [NMOD-1:0] flag_q;
    logic [NMOD-1:0] pin_q;
    logic [NMOD-1:0] irq_en;
    pcpw_mode_t      mode_q [NMOD];
    logic [7:0]      cmpl_q [NMOD];
    logic [7:0]      cmph_q [NMOD];
    pcpw_fn_t        fn_a   [NMOD];

    // Synchronisers and edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eci_q <= 3'h0;
            osc_q <= 3'h0;
        end else begin
            eci_q <= {eci_q[1:0], external_count_input};
            osc_q <= {osc_q[1:0], ext_osc_clk};
        end
    end

    // Prescalers for /12, /4 and oscillator /8
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q     <= 4'h0;
            osc_cnt_q <= 3'h0;
        end else begin
            pre_q <= (pre_q == DIV12 - 4'h1) ? 4'h0 : pre_q + 4'h1;
            if (osc_q[1] && !osc_q[2]) begin
                osc_cnt_q <= osc_cnt_q + 3'h1;
            end
        end
    end

    always_comb begin
        case (tb_q) // see RULE_25
            TB_DIV12: tb_src = (pre_q == DIV12 - 4'h1);
            TB_DIV4:  tb_src = (pre_q[1:0] == 2'h3);
            TB_T0OVF: tb_src = timer0_ovf;
            TB_ECI:   tb_src = eci_q[2] && !eci_q[1];
            TB_SYS:   tb_src = 1'b1;
            TB_OSC8:  tb_src = osc_q[1] && !osc_q[2] && (osc_cnt_q == OSC_LAST);
            default:  tb_src = 1'b0;
        endcase
    end

    // Watchdog forces the counter on unless idle gating stops it
    assign tick    = tb_src && (run_q || wd_en_q) && !(idle_q && cpu_idle); // see RULE_26 see RULE_17
    assign cnt_nxt = cnt_q + 16'h1;
    assign lo_ovf  = (cnt_q[7:0] == 8'hff);
    assign ovf16   = (cnt_q == 16'hffff);

    assign wr      = psel && penable && pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit;

    function automatic logic wr_at(input logic [AW-1:0] a, input logic [AW-1:0] o);
        return a == o;
    endfunction

    // Counter, writes blocked by the watchdog
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 16'h0;
        end else if (wr && !wd_en_q && wr_at(paddr, OFS_CNTL)) begin // see RULE_17
            cnt_q[7:0] <= pwdata[7:0];
        end else if (wr && !wd_en_q && wr_at(paddr, OFS_CNTH)) begin
            cnt_q[15:8] <= pwdata[7:0];
        end else if (tick) begin
            cnt_q <= cnt_nxt;
        end
    end

    // Counter mode register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_en_q <= WDEN_RST; // see RULE_16
            lock_q  <= 1'b0;
            tb_q    <= TB_DIV12;
            idle_q  <= 1'b0;
        end else if (wr && wr_at(paddr, OFS_MODE)) begin
            if (!wd_en_q) begin // see RULE_17
                tb_q   <= pwdata[MD_TB_LSB +: 3];
                idle_q <= pwdata[MD_IDLE];
            end
            lock_q  <= lock_q || pwdata[MD_LOCK];
            wd_en_q <= lock_q || pwdata[MD_LOCK] || pwdata[MD_WDEN]; // see RULE_24
        end
    end

    // Software run bit; reads back as written
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= 1'b0;
        end else if (wr && wr_at(paddr, OFS_CTRL)) begin
            run_q <= pwdata[CTRL_RUN]; // see RULE_18
        end
    end

    genvar m;
    generate
        for (m = 0; m < NMOD; m++) begin : g_mod
            pcpw_mode_t md;
            pcpw_fn_t   fn_prev_q;
            logic       wdm;
            logic [7:0] cmp8;
            logic       m8;
            logic       m16;
            logic       ev;

            assign wdm = (m == WD_MOD) && wd_en_q;
            always_comb begin
                md = mode_q[m];
                if (wdm) begin // see RULE_17
                    md     = '0;
                    md.ecom = 1'b1;
                    md.mat  = 1'b1;
                    md.irq_en = mode_q[m].irq_en;
                end
            end
            assign fn_a[m]   = pcpw_decode(md);
            assign irq_en[m] = md.irq_en;
            assign cmp8 = (fn_a[m] == FN_PWM8 && lo_ovf) ? cmph_q[m] : cmpl_q[m];
            assign m8   = (cnt_nxt[7:0] == cmp8);
            assign m16  = (cnt_nxt == {cmph_q[m], cmpl_q[m]}); // see RULE_01
            assign ev   = tick && ((fn_a[m] == FN_FREQ || fn_a[m] == FN_PWM8) ? m8 : m16);

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    mode_q[m] <= '0;
                end else if (wr && !wdm && wr_at(paddr, OFS_MMODE + 8'(4 * m))) begin
                    mode_q[m] <= pwdata[7:0];
                end else if (wr && wr_at(paddr, OFS_CMPL + 8'(8 * m))) begin
                    mode_q[m].ecom <= 1'b0; // see RULE_04
                end else if (wr && wr_at(paddr, OFS_CMPH + 8'(8 * m))) begin
                    mode_q[m].ecom <= 1'b1; // see RULE_04
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cmpl_q[m] <= 8'h0;
                end else if (wr && wr_at(paddr, OFS_CMPL + 8'(8 * m))) begin
                    cmpl_q[m] <= pwdata[7:0];
                end else if (tick && fn_a[m] == FN_FREQ && m8) begin
                    cmpl_q[m] <= cmpl_q[m] + cmph_q[m]; // see RULE_08 see RULE_09
                end else if (tick && fn_a[m] == FN_PWM8 && lo_ovf) begin
                    cmpl_q[m] <= cmph_q[m]; // see RULE_11
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cmph_q[m] <= 8'h0;
                end else if (wr && wr_at(paddr, OFS_CMPH + 8'(8 * m))) begin
                    cmph_q[m] <= wdm ? cnt_q[15:8] + cmpl_q[m] : pwdata[7:0]; // see RULE_20 see RULE_21
                end
            end

            // Set wins over a software clear
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    flag_q[m] <= 1'b0;
                end else if (ev && fn_a[m] != FN_OFF) begin
                    flag_q[m] <= 1'b1; // see RULE_01
                end else if (wr && wr_at(paddr, OFS_CTRL) && !pwdata[m]) begin
                    flag_q[m] <= 1'b0; // see RULE_02
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    fn_prev_q <= FN_OFF;
                    pin_q[m]  <= 1'b0;
                end else begin
                    fn_prev_q <= fn_a[m];
                    case (fn_a[m])
                        FN_HSO: begin
                            if (fn_prev_q != FN_HSO) begin
                                pin_q[m] <= 1'b1; // see RULE_07
                            end else if (ev) begin
                                pin_q[m] <= !pin_q[m]; // see RULE_06
                            end
                        end
                        FN_FREQ: begin
                            if (ev) begin
                                pin_q[m] <= !pin_q[m]; // see RULE_08
                            end
                        end
                        FN_PWM8: begin
                            if (ev) begin
                                pin_q[m] <= 1'b1; // see RULE_10
                            end else if (tick && lo_ovf) begin
                                pin_q[m] <= 1'b0;
                            end
                        end
                        FN_PWM16: begin
                            if (ev) begin
                                pin_q[m] <= 1'b1; // see RULE_13
                            end else if (tick && ovf16) begin
                                pin_q[m] <= 1'b0;
                            end
                        end
                        FN_TIMER: pin_q[m] <= pin_q[m];
                        default:  pin_q[m] <= 1'b0; // see RULE_12 see RULE_14
                    endcase
                end
            end
        end
    endgenerate

    // Watchdog expiry and forced reset
    assign wd_hit   = wd_en_q && tick && lo_ovf && (cmph_q[WD_MOD] == cnt_q[15:8]); // see RULE_19 see RULE_22
    assign wd_force = wd_en_q && wr && wr_at(paddr, OFS_CTRL) && pwdata[WD_MOD]; // see RULE_23

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_reset <= 1'b0;
            irq_request    <= 1'b0;
        end else begin
            watchdog_reset <= wd_hit || wd_force;
            irq_request    <= |(flag_q & irq_en); // see RULE_01
        end
    end
    assign module_io_pin = pin_q;

    // Read decode
    always_comb begin
        rd_d = 32'h0;
        hit  = 1'b1;
        case (paddr)
            OFS_CTRL: rd_d = {25'h0, run_q, flag_q}; // see RULE_18
            OFS_MODE: rd_d = {24'h0, idle_q, wd_en_q, lock_q, 1'b0, tb_q, 1'b0};
            OFS_CNTL: rd_d = {24'h0, cnt_q[7:0]};
            OFS_CNTH: rd_d = {24'h0, snap_q};
            default: begin
                hit = 1'b0;
                for (int i = 0; i < NMOD; i++) begin
                    if (paddr == OFS_MMODE + 8'(4 * i)) begin
                        rd_d = {24'h0, mode_q[i]};
                        hit  = 1'b1;
                    end
                    if (paddr == OFS_CMPL + 8'(8 * i)) begin
                        rd_d = {24'h0, cmpl_q[i]};
                        hit  = 1'b1;
                    end
                    if (paddr == OFS_CMPH + 8'(8 * i)) begin
                        rd_d = {24'h0, cmph_q[i]};
                        hit  = 1'b1;
                    end
                end
            end
        endcase
    end

    // Read data captured in setup; low read latches high snapshot
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            snap_q <= 8'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_d;
            if (paddr == OFS_CNTL) begin
                snap_q <= cnt_q[15:8];
            end
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_wd_reload;
        wd_en_q && wr && paddr == OFS_CMPH + 8'(8 * WD_MOD);
    endsequence
    sequence s_low_write0;
        wr && paddr == OFS_CMPL && !(wr && paddr == OFS_MMODE);
    endsequence

    chk_low_clears_ecom: assert property (s_low_write0 |=> !mode_q[0].ecom) // see RULE_04
        else $error("low byte write left comparator enabled");
    chk_high_sets_ecom: assert property (wr && paddr == OFS_CMPH |=> mode_q[0].ecom) // see RULE_04
        else $error("high byte write did not enable comparator");
    chk_wd_reload_value: assert property (s_wd_reload |=> cmph_q[WD_MOD] == $past(cnt_q[15:8]) + $past(cmpl_q[WD_MOD]))
        else $error("watchdog reload value wrong"); // see RULE_20
    chk_wd_expiry_reset: assert property (wd_hit |=> watchdog_reset ##1 !watchdog_reset || wd_hit) // see RULE_22
        else $error("watchdog expiry gave no reset");
    chk_wd_force_reset: assert property (wd_force |=> watchdog_reset) // see RULE_23
        else $error("forced watchdog reset missing");
    chk_wd_counter_locked: assert property (wd_en_q && wr && paddr == OFS_CNTL && !tick |=> $stable(cnt_q)) // see RULE_17
        else $error("counter written while watchdog enabled");
    chk_lock_keeps_wd: assert property (lock_q |=> wd_en_q && lock_q) // see RULE_24
        else $error("locked watchdog was disabled");
    chk_flag_sticky_set: assert property (flag_q[0] && !(wr && paddr == OFS_CTRL) |=> flag_q[0]) // see RULE_02
        else $error("compare flag cleared without a write");
    chk_timer_match_flag: assert property (tick && fn_a[0] == FN_TIMER && cnt_nxt == {cmph_q[0], cmpl_q[0]}
        |=> flag_q[0]) // see RULE_01
        else $error("timer match did not set flag");

    // Pin and interrupt outputs, watchdog module mode
    chk_irq_follows_flag: assert property (|(flag_q & irq_en) |=> irq_request) // see RULE_01
        else $error("enabled flag raised no interrupt");
    chk_hso_starts_high: assert property (fn_a[1] == FN_HSO && g_mod[1].fn_prev_q != FN_HSO |=> module_io_pin[1]) // see RULE_07
        else $error("toggle output did not start high");
    chk_freq_pin_toggle: assert property (fn_a[2] == FN_FREQ && g_mod[2].ev |=> module_io_pin[2] != $past(module_io_pin[2])) // see RULE_08
        else $error("frequency output did not toggle");
    chk_pwm8_ovf_low: assert property (fn_a[3] == FN_PWM8 && tick && lo_ovf && !g_mod[3].ev |=> !module_io_pin[3]) // see RULE_10
        else $error("pwm8 pin not low after overflow");
    chk_off_pin_low: assert property (fn_a[3] == FN_OFF |=> !module_io_pin[3]) // see RULE_12
        else $error("disabled module drove its pin");
    chk_pwm16_ovf_low: assert property (fn_a[4] == FN_PWM16 && tick && ovf16 && !g_mod[4].ev |=> !module_io_pin[4]) // see RULE_13
        else $error("pwm16 pin not low after overflow");
    chk_wd_forced_timer: assert property (wd_en_q |-> fn_a[WD_MOD] == FN_TIMER) // see RULE_17
        else $error("watchdog module not in timer mode");
endmodule

// [bench/pcpw_src_model.sv]
/*
 Far-side model: the timebase sources wired to the counter array.
 Assumes pclk comes from the bench; every source steps on its rising edge.
*/
`timescale 1ns/1ps
module pcpw_src_model (
    // Clock
    input  wire logic pclk,
    // Timebase sources
    output logic      timer0_ovf,
    output logic      external_count_input,
    output logic      ext_osc_clk
);
    logic [2:0] t_q = 3'h0;
    logic [2:0] e_q = 3'h0;

    // Overflow every 5 pclk, count pin period 8, oscillator period 4
    always_ff @(posedge pclk) begin
        t_q <= (t_q == 3'h4) ? 3'h0 : t_q + 3'h1;
        e_q <= e_q + 3'h1;
    end

    assign timer0_ovf           = (t_q == 3'h0);
    assign external_count_input = e_q[2];
    assign ext_osc_clk          = e_q[1];
endmodule

// [bench/pcpw_counter_array_test.sv]
/*
 Self-checking bench: APB register calls, watchdog and pin timing checks.
 Assumes zero-wait APB slave and the timebase model beside it.
*/
`timescale 1ns/1ps
module pcpw_counter_array_test;
    import pcpw_pkg::*;

    logic        pclk;
    logic        presetn;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        timer0_ovf;
    logic        external_count_input;
    logic        ext_osc_clk;
    logic        cpu_idle;
    logic [5:0]  module_io_pin;
    logic        irq_request;
    logic        watchdog_reset;
    logic [7:0]  watch;
    logic        last_err;
    int          fail_count;
    int          compares;
    int          n;
    int          h;
    int          gap_x[6] = '{48, 16, 20, 32, 4, 128};

    assign watch = {watchdog_reset, irq_request, module_io_pin};

    pcpw_counter_array DUT (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .timer0_ovf(timer0_ovf), .external_count_input(external_count_input),
        .ext_osc_clk(ext_osc_clk), .cpu_idle(cpu_idle), .module_io_pin(module_io_pin),
        .irq_request(irq_request), .watchdog_reset(watchdog_reset)
    );

    pcpw_src_model SRC (
        .pclk(pclk), .timer0_ovf(timer0_ovf), .external_count_input(external_count_input),
        .ext_osc_clk(ext_osc_clk)
    );

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task test_done();
        $display("compares=%0d mismatches=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; called just after a rising edge
    task apb(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [31:0] q);
        int k;
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        q = prdata;
        last_err = pslverr;
        {psel, penable} <= 2'b00;
        if (k >= 50) begin
            fail_count++;
            test_done();
        end
        @(posedge pclk);
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        apb(a, 1'b1, d, q);
    endtask

    task rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] msk);
        logic [31:0] q;
        apb(a, 1'b0, 8'h00, q);
        chk(q & {24'h0, msk}, {24'h0, exp});
    endtask

    // Cycles until watch bit i changes, bounded
    task wait_chg(input int i, input int bound, output int c);
        logic prev;
        prev = watch[i];
        c = 0;
        do begin
            @(posedge pclk);
            c++;
        end while (watch[i] === prev && c < bound);
        if (c >= bound) begin
            fail_count++;
            test_done();
        end
    endtask

    task hi_time(input int i, output int c);
        if (watch[i] === 1'b1) wait_chg(i, 400, c);
        wait_chg(i, 400, c);
        wait_chg(i, 400, c);
    endtask

    task do_reset();
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
    endtask

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, cpu_idle} = '0;
        fail_count = 0;
        compares = 0;
        do_reset();
        rd(OFS_MODE, 8'h40, 8'hff);
        rd(OFS_CTRL, 8'h00, 8'hff);
        wr(OFS_MODE, 8'h48);
        rd(OFS_MODE, 8'h40, 8'hff);
        wr(OFS_CNTH, 8'h80);
        rd(OFS_CNTL, 8'h00, 8'h00);
        rd(OFS_CNTH, 8'h00, 8'hff);
        rd(8'hfc, 8'h00, 8'hff);
        chk({31'h0, last_err}, 32'h1);
        wr(OFS_CTRL, 8'h20);
        wait_chg(7, 8, n);
        wr(OFS_MODE, 8'h20);
        wr(OFS_MODE, 8'h00);
        rd(OFS_MODE, 8'h60, 8'hff);
        $display("test registers_and_lock done");
        do_reset();
        wait_chg(7, 12000, n);
        chk(32'(n >= 256 * 12 - 8 && n <= 256 * 12 + 8), 32'h1);
        $display("test default_timeout done");
        do_reset();
        wr(OFS_CMPL + 8'h28, 8'h02);
        wr(OFS_CMPH + 8'h28, 8'h33);
        wait_chg(7, 12000, n);
        n = n + 6;
        chk(32'(n >= 768 * 12 - 8 && n <= 768 * 12 + 8), 32'h1);
        $display("test reload_timeout done");
        do_reset();
        wr(OFS_MODE, 8'h00);
        rd(OFS_MODE, 8'h00, 8'hff);
        wr(OFS_MODE, {4'h0, TB_SYS, 1'b0});
        wr(OFS_MMODE, 8'h49);
        wr(OFS_CMPL, 8'h20);
        rd(OFS_MMODE, 8'h09, 8'hff);
        wr(OFS_CMPH, 8'h00);
        rd(OFS_MMODE, 8'h49, 8'hff);
        wr(OFS_CMPL + 8'h08, 8'h10);
        wr(OFS_CMPH + 8'h08, 8'h00);
        wr(OFS_MMODE + 8'h04, 8'h4c);
        @(posedge pclk);
        chk({31'h0, watch[1]}, 32'h1);
        wr(OFS_CMPL + 8'h10, 8'h00);
        wr(OFS_CMPH + 8'h10, 8'h04);
        wr(OFS_MMODE + 8'h08, 8'h46);
        wr(OFS_CMPL + 8'h18, 8'h00);
        wr(OFS_CMPH + 8'h18, 8'h40);
        wr(OFS_MMODE + 8'h0c, 8'h42);
        wr(OFS_CMPL + 8'h20, 8'h80);
        wr(OFS_CMPH + 8'h20, 8'hff);
        wr(OFS_MMODE + 8'h10, 8'hc3);
        wr(OFS_CTRL, 8'h40);
        wait_chg(1, 100, n);
        chk({31'h0, watch[1]}, 32'h0);
        wait_chg(6, 100, n);
        rd(OFS_CTRL, 8'h41, 8'h41);
        repeat (50) @(posedge pclk);
        rd(OFS_CTRL, 8'h01, 8'h01);
        wr(OFS_CTRL, 8'h40);
        rd(OFS_CTRL, 8'h00, 8'h01);
        chk({31'h0, watch[6]}, 32'h0);
        $display("test timer_and_toggle done");
        for (int c = 0; c < 6; c++) begin
            wr(OFS_MODE, {4'h0, 3'(c), 1'b0});
            wait_chg(2, (c == 0) ? 4000 : 400, n);
            wait_chg(2, 400, n);
            chk(32'(n), 32'(gap_x[c]));
        end
        wr(OFS_MODE, {4'h0, TB_SYS, 1'b0});
        wr(OFS_CMPH + 8'h10, 8'h00);
        wait_chg(2, 400, n);
        wait_chg(2, 400, n);
        chk(32'(n), 32'd256);
        $display("test frequency_output done");
        hi_time(3, n);
        hi_time(3, n);
        chk(32'(n), 32'd192);
        wr(OFS_CMPL + 8'h18, 8'h00);
        h = 0;
        repeat (300) begin
            @(posedge pclk);
            if (watch[3] !== 1'b0) h++;
        end
        chk(32'(h), 32'd0);
        wr(OFS_CNTL, 8'h00);
        wr(OFS_CNTH, 8'hff);
        hi_time(4, n);
        chk(32'(n), 32'd128);
        $display("test pulse_width done");
        test_done();
    end
endmodule
